// *** include/sss_pkg.sv ***
//------------------------------------------------------------------------------
// Purpose: Constants and carriers for the synchronous serial slave port
// Assumes: 8-bit register port, 3-bit register index, one system clock
// Notes:   Register indices are local choices; bit positions follow the map
//------------------------------------------------------------------------------
package sss_pkg;

    //--------------------------------------------------------------------------
    // Widths
    //--------------------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CHAR_W = 9;
    localparam int FIFO_DEPTH = 2;

    //--------------------------------------------------------------------------
    // Register indices
    //--------------------------------------------------------------------------
    localparam logic [2:0] REG_CORE_INT_CTL = 3'h0;
    localparam logic [2:0] REG_PERIPH_IRQ_EN = 3'h1;
    localparam logic [2:0] REG_PERIPH_IRQ_FLAGS = 3'h2;
    localparam logic [2:0] REG_RX_STATUS_CTL = 3'h3;
    localparam logic [2:0] REG_PORT_C_DIR = 3'h4;
    localparam logic [2:0] REG_TX_HOLDING = 3'h5;
    localparam logic [2:0] REG_TX_STATUS_CTL = 3'h6;
    localparam logic [2:0] REG_RX_DATA = 3'h7;

    //--------------------------------------------------------------------------
    // Field positions
    //--------------------------------------------------------------------------
    localparam int B_GLOBAL_IRQ_EN = 7;
    localparam int B_PERIPH_IRQ_EN = 6;
    localparam int B_RX_IRQ_EN = 5;
    localparam int B_TX_IRQ_EN = 4;
    localparam int B_RX_READY_FLAG = 5;
    localparam int B_TX_EMPTY_FLAG = 4;
    localparam int B_PORT_EN = 7;
    localparam int B_RX_NINE_EN = 6;
    localparam int B_SINGLE_RX_EN = 5;
    localparam int B_CONT_RX_EN = 4;
    localparam int B_ADDR_DETECT_EN = 3;
    localparam int B_FRAMING_ERR = 2;
    localparam int B_OVERRUN_ERR = 1;
    localparam int B_RX_NINTH_BIT = 0;
    localparam int B_CLK_SRC_MASTER = 7;
    localparam int B_TX_NINE_EN = 6;
    localparam int B_TX_EN = 5;
    localparam int B_SYNC_MODE = 4;
    localparam int B_HIGH_BAUD = 2;
    localparam int B_TX_SHIFT_EMPTY = 1;
    localparam int B_TX_NINTH_BIT = 0;
    localparam int B_CLK_PIN_DIR = 6;

    //--------------------------------------------------------------------------
    // Reset values and write masks
    //--------------------------------------------------------------------------
    localparam logic [7:0] CORE_INT_CTL_RST = 8'h00;
    localparam logic [7:0] PERIPH_IRQ_EN_RST = 8'h00;
    localparam logic [7:0] RX_STATUS_CTL_RST = 8'h00;
    localparam logic [7:0] PORT_C_DIR_RST = 8'hff;
    localparam logic [7:0] TX_STATUS_CTL_RST = 8'h02;
    localparam logic [7:0] RX_CTL_WMASK = 8'hf8;
    localparam logic [7:0] TX_CTL_WMASK = 8'hf5;
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG = 4'h9;
    localparam logic [12:0] ISR_VECTOR = 13'h0004;

    //--------------------------------------------------------------------------
    // Types
    //--------------------------------------------------------------------------
    typedef enum logic [0:0] {
        SSS_TX_IDLE = 1'b0,
        SSS_TX_SHIFT = 1'b1
    } sss_tx_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic wrStb;
        logic rdStb;
    } sss_bus_req_t;

    typedef struct packed {
        logic [7:0] coreIntCtl;
        logic [7:0] periphIrqEn;
        logic [7:0] portCDir;
        logic [7:0] rxCtl;
        logic [7:0] txCtl;
        logic overrun;
        logic [CHAR_W-1:0] txHold;
        logic txHoldFull;
        sss_tx_state_t txState;
        logic [CHAR_W-1:0] txShift;
        logic [3:0] txCount;
        logic [CHAR_W-1:0] rxShift;
        logic [3:0] rxCount;
        logic [FIFO_DEPTH-1:0][CHAR_W-1:0] rxFifo;
        logic [1:0] rxLevel;
        logic [2:0] clkSync;
        logic [1:0] dataSync;
        logic [7:0] rdData;
        logic serDataOut;
        logic serDataOe;
        logic serClkOe;
        logic coreWake;
        logic coreVector;
        logic [12:0] vectorAddr;
    } sss_state_t;

endpackage

// *** rtl/sss_sync_slave.sv ***
//------------------------------------------------------------------------------
// Purpose: Synchronous slave mode of an addressable serial port
// Assumes: Serial clock idles low; leading edge is rising, trailing is falling
// Notes:   Serial clock and data are sampled by mclk and edge detected
//------------------------------------------------------------------------------
// Notes on behaviour
// - Write to empty holding register moves at once into shifter and starts.
// - Second write while shifting stays held; buffer empty flag remains clear.
// - After shifter empties, pending character moves in and empty flag sets in the same cycle.
// - Empty flag with peripheral and transmit enables wakes sleeping core.
// - Slave mode needs sync select and port enable set, clock master clear.
// - Slave mode transmits when both receive enables are clear.
// - Nine-bit transmit sends stored ninth bit as character's top bit.
// - Writing low eight bits to holding register starts transmit when enabled.
// - No slave transmission until transmit enable is set.
// - Slave reception runs while continuous enable set; single enable ignored.
// - Completed character moves to receive data register, also during sleep.
// - Receive interrupt with its enable and peripheral enable set wakes the sleeping core.
// - Nine-bit receive shifts nine bits; top bit shown as ninth bit field.
// - Receive ready flag sets on completion; interrupt if enabled.
// - Clearing continuous receive enable clears overrun error.
// - During sleep only synchronous slave mode keeps shifting.
// - Slave shifters move only on edges of the master's serial clock.
// - Reading receive data pops buffer; ready flag clears when empty.
// - On wake core runs next instruction; with global enable, vectors 0004h.
// - Transmit data changes on leading edge, one bit per clock cycle.
// - Two-character buffer; third character sets overrun, keeps data, stops.
// - Clock pin driver is off whenever configured as synchronous slave.
`timescale 1ns/100ps

module sss_sync_slave
    import sss_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    input wire sss_bus_req_t busReq,
    output logic [DATA_W-1:0] busRdData,
    input wire logic serClkIn,
    output logic serClkOut,
    output logic serClkOe,
    input wire logic serDataIn,
    output logic serDataOut,
    output logic serDataOe,
    input wire logic coreSleep,
    output logic coreWake,
    output logic coreVector,
    output logic [12:0] coreVectorAddr
);

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    // Character length shared by both shifters
    function automatic logic [3:0] charBits(input logic nine);
        charBits = nine ? BITS_LONG : BITS_SHORT;
    endfunction

    // An 8-bit character ends up in the top bits of the right-shifting register
    function automatic logic [CHAR_W-1:0] rxAlign(input logic [CHAR_W-1:0] sr,
                                                  input logic nine);
        rxAlign = nine ? sr : {1'b0, sr[CHAR_W-1:1]};
    endfunction

    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    sss_state_t s_r;
    sss_state_t s_nxt;

    logic portEn;
    logic syncMode;
    logic clkMaster;
    logic slaveMode;
    logic contRx;
    logic singleRx;
    logic txMode;
    logic rxMode;
    logic txEnable;
    logic txNine;
    logic rxNine;
    logic clkRise;
    logic clkFall;
    logic txEmpty;
    logic rxReady;
    logic irqPending;

    assign portEn = s_r.rxCtl[B_PORT_EN];
    assign syncMode = s_r.txCtl[B_SYNC_MODE];
    assign clkMaster = s_r.txCtl[B_CLK_SRC_MASTER];
    assign slaveMode = portEn & syncMode & ~clkMaster;
    assign contRx = s_r.rxCtl[B_CONT_RX_EN];
    assign singleRx = s_r.rxCtl[B_SINGLE_RX_EN];
    assign txMode = slaveMode & ~contRx & ~singleRx;
    assign rxMode = slaveMode & contRx;
    assign txEnable = s_r.txCtl[B_TX_EN];
    assign txNine = s_r.txCtl[B_TX_NINE_EN];
    assign rxNine = s_r.rxCtl[B_RX_NINE_EN];
    // Edges come from the second and third stages only
    assign clkRise = s_r.clkSync[1] & ~s_r.clkSync[2];
    assign clkFall = ~s_r.clkSync[1] & s_r.clkSync[2];
    assign txEmpty = ~s_r.txHoldFull;
    assign rxReady = (s_r.rxLevel != 2'h0);
    assign irqPending = s_r.coreIntCtl[B_PERIPH_IRQ_EN] &
        ((txEmpty & s_r.periphIrqEn[B_TX_IRQ_EN]) |
         (rxReady & s_r.periphIrqEn[B_RX_IRQ_EN]));

    //--------------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------------
    always_comb
    begin
        logic pop;
        logic done;
        logic [1:0] level;
        logic [CHAR_W-1:0] rxChar;
        pop = 1'b0;
        done = 1'b0;
        level = 2'h0;
        rxChar = '0;
        s_nxt = s_r;

        // Link inputs pass two flops before any logic sees them
        s_nxt.clkSync = {s_r.clkSync[1], s_r.clkSync[0], serClkIn};
        s_nxt.dataSync = {s_r.dataSync[0], serDataIn};

        // Transmit shifter; gated by slave mode, so it never runs on mclk alone
        case (s_r.txState)
            SSS_TX_IDLE:
            begin
                if (txMode && txEnable && s_r.txHoldFull)
                begin
                    s_nxt.txShift = s_r.txHold;
                    s_nxt.txCount = charBits(txNine);
                    s_nxt.txHoldFull = 1'b0;
                    s_nxt.txState = SSS_TX_SHIFT;
                end
            end
            SSS_TX_SHIFT:
            begin
                if (!txMode || !txEnable)
                begin
                    s_nxt.txState = SSS_TX_IDLE;
                    s_nxt.txCount = 4'h0;
                end
                else if (clkRise && s_r.txCount != 4'h0)
                begin
                    // One bit per clock, placed on the leading edge
                    s_nxt.serDataOut = s_r.txShift[0];
                    s_nxt.txShift = {1'b0, s_r.txShift[CHAR_W-1:1]};
                    s_nxt.txCount = s_r.txCount - 4'h1;
                end
                else if (clkFall && s_r.txCount == 4'h0)
                begin
                    // Last bit held through its trailing edge before release
                    s_nxt.txState = SSS_TX_IDLE;
                end
            end
            default:
            begin
                s_nxt.txState = SSS_TX_IDLE;
            end
        endcase

        // Receive buffer pop; the head sits at index 0
        if (busReq.rdStb && busReq.addr == REG_RX_DATA && rxReady)
        begin
            pop = 1'b1;
            s_nxt.rxFifo[0] = s_r.rxFifo[1];
        end
        level = s_r.rxLevel - {1'b0, pop};

        // Receive shifter; the single receive enable plays no part here
        if (!contRx)
        begin
            s_nxt.overrun = 1'b0;
            s_nxt.rxCount = 4'h0;
        end
        else if (rxMode && !s_r.overrun && clkFall)
        begin
            s_nxt.rxShift = {s_r.dataSync[1], s_r.rxShift[CHAR_W-1:1]};
            if (s_r.rxCount + 4'h1 == charBits(rxNine))
            begin
                done = 1'b1;
                s_nxt.rxCount = 4'h0;
                rxChar = rxAlign(s_nxt.rxShift, rxNine);
            end
            else
            begin
                s_nxt.rxCount = s_r.rxCount + 4'h1;
            end
        end

        // Completed character lands in the buffer, sleep or not
        if (done)
        begin
            if (level == 2'(FIFO_DEPTH))
            begin
                // Buffered data is kept and reception stops
                s_nxt.overrun = 1'b1;
            end
            else
            begin
                s_nxt.rxFifo[level[0]] = rxChar;
                level = level + 2'h1;
            end
        end
        s_nxt.rxLevel = level;

        // Register writes; a holding write after a move in the same cycle wins
        if (busReq.wrStb)
        begin
            case (busReq.addr)
                REG_CORE_INT_CTL: s_nxt.coreIntCtl = busReq.wrData;
                REG_PERIPH_IRQ_EN: s_nxt.periphIrqEn = busReq.wrData;
                REG_PORT_C_DIR: s_nxt.portCDir = busReq.wrData;
                // Address detect is stored but has no effect in this mode
                REG_RX_STATUS_CTL: s_nxt.rxCtl = busReq.wrData & RX_CTL_WMASK;
                REG_TX_STATUS_CTL: s_nxt.txCtl = busReq.wrData & TX_CTL_WMASK;
                REG_TX_HOLDING:
                begin
                    if (txEnable)
                    begin
                        // Held here while the shifter is busy, so the flag stays clear
                        s_nxt.txHold = {s_r.txCtl[B_TX_NINTH_BIT], busReq.wrData};
                        s_nxt.txHoldFull = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Read data exists only in the cycle after the strobe
        s_nxt.rdData = 8'h00;
        if (busReq.rdStb)
        begin
            case (busReq.addr)
                REG_CORE_INT_CTL: s_nxt.rdData = s_r.coreIntCtl;
                REG_PERIPH_IRQ_EN: s_nxt.rdData = s_r.periphIrqEn;
                REG_PERIPH_IRQ_FLAGS:
                begin
                    s_nxt.rdData[B_RX_READY_FLAG] = rxReady;
                    s_nxt.rdData[B_TX_EMPTY_FLAG] = txEmpty;
                end
                REG_RX_STATUS_CTL:
                begin
                    s_nxt.rdData = s_r.rxCtl & RX_CTL_WMASK;
                    s_nxt.rdData[B_FRAMING_ERR] = 1'b0;
                    s_nxt.rdData[B_OVERRUN_ERR] = s_r.overrun;
                    s_nxt.rdData[B_RX_NINTH_BIT] = s_r.rxFifo[0][CHAR_W-1];
                end
                REG_PORT_C_DIR: s_nxt.rdData = s_r.portCDir;
                REG_TX_STATUS_CTL:
                begin
                    s_nxt.rdData = s_r.txCtl & TX_CTL_WMASK;
                    s_nxt.rdData[B_TX_SHIFT_EMPTY] = (s_r.txState == SSS_TX_IDLE);
                end
                REG_RX_DATA: s_nxt.rdData = s_r.rxFifo[0][7:0];
                default: s_nxt.rdData = 8'h00;
            endcase
        end

        // Pins: the master owns the clock line in slave mode
        s_nxt.serClkOe = ~slaveMode & portEn & syncMode & clkMaster &
            ~s_r.portCDir[B_CLK_PIN_DIR];
        s_nxt.serDataOe = txMode & txEnable;

        // Core wake and vectoring
        s_nxt.coreWake = coreSleep & irqPending;
        s_nxt.coreVector = irqPending & s_r.coreIntCtl[B_GLOBAL_IRQ_EN];
        s_nxt.vectorAddr = ISR_VECTOR;
    end

    //--------------------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s_r <= '0;
            s_r.coreIntCtl <= CORE_INT_CTL_RST;
            s_r.periphIrqEn <= PERIPH_IRQ_EN_RST;
            s_r.rxCtl <= RX_STATUS_CTL_RST;
            s_r.portCDir <= PORT_C_DIR_RST;
            s_r.txCtl <= TX_STATUS_CTL_RST & TX_CTL_WMASK;
            s_r.txState <= SSS_TX_IDLE;
        end
        else if (clkEn)
        begin
            s_r <= s_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------------
    assign busRdData = s_r.rdData;
    assign serClkOut = 1'b0;
    assign serClkOe = s_r.serClkOe;
    assign serDataOut = s_r.serDataOut;
    assign serDataOe = s_r.serDataOe;
    assign coreWake = s_r.coreWake;
    assign coreVector = s_r.coreVector;
    assign coreVectorAddr = s_r.vectorAddr;

endmodule

// *** dv/sss_sync_slave_props.sv ***
// Purpose: Assertions on the pins of the synchronous serial slave port
// Assumes: Shadows of the control registers follow the bus writes
// Notes:   Master mode is never set up by the bench
`timescale 1ns/100ps

module sss_sync_slave_props
    import sss_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    input wire sss_bus_req_t busReq,
    input wire logic [DATA_W-1:0] busRdData,
    input wire logic serClkIn,
    input wire logic serClkOut,
    input wire logic serClkOe,
    input wire logic serDataIn,
    input wire logic serDataOut,
    input wire logic serDataOe,
    input wire logic coreSleep,
    input wire logic coreWake,
    input wire logic coreVector,
    input wire logic [12:0] coreVectorAddr
);
    //--------------------------------------------------------------------------
    // Register shadows
    //--------------------------------------------------------------------------
    logic [7:0] coreCtl_r, rxCtl_r, txCtl_r;
    logic slave, txMode, vecEn;
    assign slave = rxCtl_r[B_PORT_EN] & txCtl_r[B_SYNC_MODE] & ~txCtl_r[B_CLK_SRC_MASTER];
    assign txMode = slave & txCtl_r[B_TX_EN] & ~rxCtl_r[B_CONT_RX_EN] & ~rxCtl_r[B_SINGLE_RX_EN];
    assign vecEn = coreCtl_r[B_GLOBAL_IRQ_EN] & coreCtl_r[B_PERIPH_IRQ_EN];

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            coreCtl_r <= 8'h00;
            rxCtl_r <= 8'h00;
            txCtl_r <= 8'h00;
        end
        else if (clkEn && busReq.wrStb)
        begin
            if (busReq.addr == REG_CORE_INT_CTL)
                coreCtl_r <= busReq.wrData;
            if (busReq.addr == REG_RX_STATUS_CTL)
                rxCtl_r <= busReq.wrData;
            if (busReq.addr == REG_TX_STATUS_CTL)
                txCtl_r <= busReq.wrData;
        end
    end

    //--------------------------------------------------------------------------
    // Properties
    //--------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_rst_out; $fell(srst) |-> busRdData == 8'h00 && !serDataOe && !coreWake; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
    property p_rd_idle; !$past(busReq.rdStb) |-> busRdData == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_clk_oe; $past(slave) |-> !serClkOe; endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock pin driven in slave mode");
    property p_vec_addr; !$past(srst) |-> coreVectorAddr == ISR_VECTOR; endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address");
    property p_wake; coreWake |-> $past(coreSleep); endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_vector; coreVector |-> $past(vecEn); endproperty
    a_vector: assert property (p_vector) else $error("vector without enables");
    property p_data_oe; !$past(srst) |-> serDataOe == $past(txMode); endproperty
    a_data_oe: assert property (p_data_oe) else $error("data pin drive wrong");
    property p_tx_stable;
        serClkIn && $past(serClkIn, 8) && $past(serDataOe) |-> $stable(serDataOut);
    endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("data moved late");
endmodule

bind sss_sync_slave sss_sync_slave_props sss_sync_slave_props_inst (.mclk(mclk), .srst(srst),
    .clkEn(clkEn), .busReq(busReq), .busRdData(busRdData), .serClkIn(serClkIn),
    .serClkOut(serClkOut), .serClkOe(serClkOe), .serDataIn(serDataIn),
    .serDataOut(serDataOut), .serDataOe(serDataOe), .coreSleep(coreSleep),
    .coreWake(coreWake), .coreVector(coreVector), .coreVectorAddr(coreVectorAddr));

// *** dv/sss_ext_master.sv ***
// Purpose: External synchronous master that clocks the slave port
// Assumes: Clock idles low, 160 ns period, LSB first
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/100ps

module sss_ext_master (
    output logic serClk,
    output logic mstData,
    input wire logic wireData,
    output logic [8:0] capWord,
    output logic [7:0] capCnt
);
    initial
    begin
        serClk = 1'b0;
        mstData = 1'b0;
        capWord = 9'h000;
        capCnt = 8'h00;
    end

    // Clock stands low outside frames; odd start offset keeps phase unrelated
    task automatic frame(input int n, input logic [8:0] d);
        logic [8:0] cap;
        cap = 9'h000;
        #1.3;
        for (int i = 0; i < n; i++)
        begin
            mstData = d[i];
            serClk = 1'b1;
            #80;
            serClk = 1'b0;
            cap[i] = wireData;
            #80;
        end
        mstData = ~mstData;
        capWord = cap;
        capCnt = capCnt + 8'h01;
    endtask
endmodule

// *** dv/sss_sync_slave_tb.sv ***
// Purpose: Self-checking bench for the synchronous serial slave port
// Assumes: clkEn held high; address detect always kept clear
// Notes:   Reads and link words are checked from expectation queues
`timescale 1ns/100ps

module sss_sync_slave_tb
    import sss_pkg::*;
;
    logic mclk, srst, clkEn, coreSleep, rdPend, serClk, mstData, dataWire;
    logic serDataOut, serDataOe, coreWake, coreVector;
    sss_bus_req_t busReq;
    logic [DATA_W-1:0] busRdData;
    logic [12:0] coreVectorAddr;
    logic [8:0] capWord, d9;
    logic [7:0] capCnt, a, b;
    logic [7:0] r[3];
    logic [7:0] rstVal[8] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'hff, 8'h00, 8'h02, 8'h00};
    logic [10:0] hd;
    logic [10:0] rdQ[$];
    logic [8:0] serQ[$];
    int nFail, totalChecks, seed;
    assign dataWire = serDataOe ? serDataOut : mstData;

    sss_sync_slave sss_sync_slave_inst (.mclk(mclk), .srst(srst), .clkEn(clkEn), .busReq(busReq),
        .busRdData(busRdData), .serClkIn(serClk), .serClkOut(), .serClkOe(),
        .serDataIn(dataWire), .serDataOut(serDataOut), .serDataOe(serDataOe),
        .coreSleep(coreSleep), .coreWake(coreWake), .coreVector(coreVector),
        .coreVectorAddr(coreVectorAddr));
    sss_ext_master sss_ext_master_inst (.serClk(serClk), .mstData(mstData),
        .wireData(dataWire), .capWord(capWord), .capCnt(capCnt));

    //--------------------------------------------------------------------------
    // Tasks and monitors
    //--------------------------------------------------------------------------
    task automatic cmp(input string nm, input logic [12:0] e, input logic [12:0] g);
        totalChecks++;
        if (g !== e)
        begin
            nFail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        @(posedge mclk);
        busReq <= '{addr: ad, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
        @(posedge mclk);
        busReq.wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] ad, input logic [7:0] e);
        rdQ.push_back({ad, e});
        @(posedge mclk);
        busReq <= '{addr: ad, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
        @(posedge mclk);
        busReq.rdStb <= 1'b0;
    endtask
    task automatic xfer(input int n, input logic [8:0] d, input logic [8:0] e);
        serQ.push_back(e);
        sss_ext_master_inst.frame(n, d);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        if (rdPend)
        begin
            hd = rdQ.pop_front();
            cmp($sformatf("register %0d", hd[10:8]), hd[7:0], busRdData);
        end
        rdPend <= busReq.rdStb;
    end
    always @(capCnt)
        if (capCnt !== 8'h00)
            cmp("link word", serQ.pop_front(), capWord);

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        nFail++;
        print_verdict();
    end

    //--------------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------------
    initial
    begin
        {seed, srst, clkEn, coreSleep, rdPend, busReq, nFail, totalChecks} = '0;
        seed = 89;
        srst = 1'b1;
        clkEn = 1'b1;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(3'(i), rstVal[i]);
        a = 8'($random(seed));
        b = 8'($random(seed));
        wr(REG_PERIPH_IRQ_EN, 8'h10);
        wr(REG_CORE_INT_CTL, 8'h40);
        wr(REG_RX_STATUS_CTL, 8'h80);
        wr(REG_TX_STATUS_CTL, 8'h10);
        wr(REG_TX_HOLDING, 8'h5a);
        rd(REG_PERIPH_IRQ_FLAGS, 8'h10);
        wr(REG_TX_STATUS_CTL, 8'h30);
        rd(REG_TX_STATUS_CTL, 8'h32);
        wr(REG_TX_HOLDING, a);
        wr(REG_TX_HOLDING, b);
        rd(REG_PERIPH_IRQ_FLAGS, 8'h00);
        coreSleep <= 1'b1;
        @(negedge mclk);
        cmp("coreWake", 1'b0, coreWake);
        xfer(8, 9'($random(seed)), {1'b0, a});
        @(negedge mclk);
        cmp("coreWake", 1'b1, coreWake);
        xfer(8, 9'($random(seed)), {1'b0, b});
        wr(REG_TX_STATUS_CTL, 8'h71);
        wr(REG_TX_HOLDING, a);
        xfer(9, 9'($random(seed)), {1'b1, a});
        wr(REG_CORE_INT_CTL, 8'hc0);
        repeat (2) @(negedge mclk);
        cmp("coreVector", 1'b1, coreVector);
        wr(REG_TX_STATUS_CTL, 8'h10);
        wr(REG_CORE_INT_CTL, 8'h40);
        wr(REG_PERIPH_IRQ_EN, 8'h20);
        wr(REG_RX_STATUS_CTL, 8'hb0);
        xfer(8, {1'b0, b}, {1'b0, b});
        @(negedge mclk);
        cmp("coreWake", 1'b1, coreWake);
        rd(REG_PERIPH_IRQ_FLAGS, 8'h30);
        rd(REG_RX_DATA, b);
        rd(REG_PERIPH_IRQ_FLAGS, 8'h10);
        for (int i = 0; i < 3; i++)
        begin
            r[i] = 8'($random(seed));
            xfer(8, {1'b0, r[i]}, {1'b0, r[i]});
        end
        rd(REG_RX_STATUS_CTL, 8'hb2);
        rd(REG_RX_DATA, r[0]);
        rd(REG_RX_DATA, r[1]);
        rd(REG_PERIPH_IRQ_FLAGS, 8'h10);
        wr(REG_RX_STATUS_CTL, 8'ha0);
        rd(REG_RX_STATUS_CTL, 8'ha0);
        wr(REG_RX_STATUS_CTL, 8'hd0);
        d9 = 9'($random(seed));
        xfer(9, d9, d9);
        rd(REG_RX_STATUS_CTL, 8'hd0 | {7'h00, d9[8]});
        rd(REG_RX_DATA, d9[7:0]);
        coreSleep <= 1'b0;
        repeat (4) @(posedge mclk);
        print_verdict();
    end
endmodule
